// >>> rtl/urx_defines.vh
// register map, field positions, reset values and timing constants of the receiver
`ifndef URX_DEFINES_VH
`define URX_DEFINES_VH

// register addresses on the plain register port
`define URX_ADDR_CTRL    2'h0
`define URX_ADDR_DIVISOR 2'h1
`define URX_ADDR_STATUS  2'h2
`define URX_ADDR_DATA    2'h3

// serial_control_one fields
`define URX_CTRL_UNIT    0
`define URX_CTRL_RECEIVE_ENABLE    1
`define URX_CTRL_NINE    2
`define URX_CTRL_PAREN   3
`define URX_CTRL_PARODD  4
`define URX_CTRL_RIE     5
`define URX_CTRL_W       6
`define URX_CTRL_RESET   6'h00

// serial_status_register fields
`define URX_STAT_AVAIL   0
`define URX_STAT_OVR     1
`define URX_STAT_NOISE   2
`define URX_STAT_FRAMING_ERROR_FLAG    3
`define URX_STAT_PARITY_ERROR_FLAG    4
`define URX_STAT_IDLE    5
`define URX_STAT_NINTH   6

// baud divisor reset value
`define URX_DIV_RESET    8'h00

// oversampling: ticks per bit and the three centre sample points
`define URX_OVERSAMPLE   16
`define URX_PH_S1        4'h7
`define URX_PH_S2        4'h8
`define URX_PH_S3        4'h9

// word lengths
`define URX_BITS_8       4'h8
`define URX_BITS_9       4'h9
`define URX_MASK_8       9'h0ff
`define URX_MASK_9       9'h1ff

// buffer depth
`define URX_FIFO_FULL    2'h2

`endif

// >>> rtl/urx_receiver.v
// receive half of an asynchronous serial port with two-word buffer and error flags
`include "urx_defines.vh"

module urx_receiver
#(
    parameter DIV_W = 8                        // width of the baud divisor
)
(
    input  wire         i_clock,               // system clock, 40 MHz
    input  wire         i_reset,               // synchronous reset, active high
    input  wire         i_enable,              // clock enable, freezes all state when low
    input  wire         i_rx_pin,              // serial receive pin, asynchronous
    input  wire [1:0]   i_addr,                // register address
    input  wire [15:0]  i_wdata,               // register write data
    input  wire         i_wr,                  // write strobe
    input  wire         i_rd,                  // read strobe
    output reg  [15:0]  o_rdata,               // read data, one cycle after the strobe
    output reg          o_rx_irq,              // one-cycle receive interrupt request
    output wire         o_data_available,      // buffer holds an unread word
    output wire         o_receiver_idle        // receiver between frames
);

    // one-hot receiver states
    localparam [4:0] ST_IDLE  = 5'h01;         // hunting for a start edge
    localparam [4:0] ST_START = 5'h02;         // confirming the start bit
    localparam [4:0] ST_DATA  = 5'h04;         // shifting data bits
    localparam [4:0] ST_STOP  = 5'h08;         // checking the stop bit
    localparam [4:0] ST_WAITH = 5'h10;         // line held low, wait for high

    // majority of three samples
    function maj3;
        input a;
        input b;
        input c;
        begin
            maj3 = (a & b) | (a & c) | (b & c);
        end
    endfunction

    // configuration registers
    reg  [`URX_CTRL_W-1:0] ctrl_reg;           // serial_control_one
    reg  [DIV_W-1:0]       divisor_reg;        // baud_divisor

    // pin synchroniser and filtered level
    reg                    sync1_reg;          // first stage, read only by second
    reg                    sync2_reg;          // second stage
    reg                    sync3_reg;          // third stage
    reg                    level_reg;          // accepted line level
    reg                    level_prev_reg;     // level one cycle ago for edge detection

    // oversampling tick generator
    reg  [DIV_W-1:0]       div_cnt_reg;        // cycles within one tick
    wire                   tick;               // sixteen times the baud rate

    // frame engine
    reg  [4:0]             state_reg;          // receiver state
    reg  [3:0]             phase_reg;          // tick within the bit period
    reg  [3:0]             bit_cnt_reg;        // data bit index
    reg  [8:0]             shift_reg;          // receive_shift_register
    reg                    samp1_reg;          // first centre sample
    reg                    samp2_reg;          // second centre sample
    reg                    frame_noise_reg;    // samples disagreed in the start bit or a data bit
    reg                    idle_reg;           // receiver_idle_flag

    // two-word buffer: {framing, parity, nine data bits}
    reg  [10:0]            fifo_mem [0:1];     // buffer storage
    reg                    wr_ptr_reg;         // write pointer
    reg                    rd_ptr_reg;         // read pointer
    reg  [1:0]             count_reg;          // words held

    // status flags and the clear sequence
    reg                    overrun_reg;        // overrun_flag
    reg                    noise_reg;          // noise_flag
    reg                    armed_reg;          // status read seen, data read may clear

    // derived controls
    wire unit_en   = ctrl_reg[`URX_CTRL_UNIT];
    wire rx_en     = ctrl_reg[`URX_CTRL_RECEIVE_ENABLE] & unit_en;
    wire nine      = ctrl_reg[`URX_CTRL_NINE];
    wire par_en    = ctrl_reg[`URX_CTRL_PAREN];
    wire par_odd   = ctrl_reg[`URX_CTRL_PARODD];
    wire receive_interrupt_enable       = ctrl_reg[`URX_CTRL_RIE];
    wire [3:0] nbits = nine ? `URX_BITS_9 : `URX_BITS_8;
    wire [8:0] mask  = nine ? `URX_MASK_9 : `URX_MASK_8;

    // sample decision at the third centre point
    wire decide   = tick & (phase_reg == `URX_PH_S3);
    wire bit_val  = maj3(samp1_reg, samp2_reg, level_reg);
    wire bit_nz   = (samp1_reg != samp2_reg) | (samp2_reg != level_reg);

    // end of frame: word ready to go into the buffer
    wire frame_end = (state_reg == ST_STOP) & decide & rx_en;
    wire stop_bad  = ~bit_val;
    wire par_bad   = par_en & ((^(shift_reg & mask)) ^ par_odd);
    wire room      = (count_reg != `URX_FIFO_FULL);
    wire push      = frame_end & room;
    wire overrun_ev = frame_end & ~room;

    // register accesses
    wire rd_status = i_rd & (i_addr == `URX_ADDR_STATUS);
    wire rd_data   = i_rd & (i_addr == `URX_ADDR_DATA);
    wire pop       = rd_data & armed_reg & (count_reg != 2'h0);
    wire [10:0] head = fifo_mem[rd_ptr_reg];

    assign tick             = (div_cnt_reg == divisor_reg);
    assign o_data_available = (count_reg != 2'h0);
    assign o_receiver_idle  = idle_reg;

    // configuration writes; disabling the unit also drops receive enable
    always @(posedge i_clock)
    begin
        if (i_reset)
        begin
            ctrl_reg    <= `URX_CTRL_RESET;
            divisor_reg <= `URX_DIV_RESET;
        end
        else if (i_enable)
        begin
            if (i_wr & (i_addr == `URX_ADDR_CTRL))
            begin
                ctrl_reg <= i_wdata[`URX_CTRL_W-1:0];
                // a write that clears the unit bit clears receive enable too
                if (!i_wdata[`URX_CTRL_UNIT])
                    ctrl_reg[`URX_CTRL_RECEIVE_ENABLE] <= 1'b0;
            end
            else if (!unit_en)
            begin
                ctrl_reg[`URX_CTRL_RECEIVE_ENABLE] <= 1'b0;
            end
            if (i_wr & (i_addr == `URX_ADDR_DIVISOR))
                divisor_reg <= i_wdata[DIV_W-1:0];
        end
    end

    // three-stage pin synchroniser; a change counts once stages two and three agree
    always @(posedge i_clock)
    begin
        if (i_reset)
        begin
            sync1_reg      <= 1'b1;
            sync2_reg      <= 1'b1;
            sync3_reg      <= 1'b1;
            level_reg      <= 1'b1;
            level_prev_reg <= 1'b1;
        end
        else if (i_enable)
        begin
            sync1_reg      <= i_rx_pin;
            sync2_reg      <= sync1_reg;
            sync3_reg      <= sync2_reg;
            if (sync2_reg == sync3_reg)
                level_reg <= sync3_reg;
            level_prev_reg <= level_reg;
        end
    end

    // oversampling tick: one tick every divisor plus one cycles
    always @(posedge i_clock)
    begin
        if (i_reset)
            div_cnt_reg <= {DIV_W{1'b0}};
        else if (i_enable)
        begin
            if (tick)
                div_cnt_reg <= {DIV_W{1'b0}};
            else
                div_cnt_reg <= div_cnt_reg + 1'b1;
        end
    end

    // frame engine: start detect, centre sampling, data shift, stop check
    always @(posedge i_clock)
    begin
        if (i_reset)
        begin
            state_reg       <= ST_IDLE;
            phase_reg       <= 4'h0;
            bit_cnt_reg     <= 4'h0;
            shift_reg       <= 9'h000;
            samp1_reg       <= 1'b1;
            samp2_reg       <= 1'b1;
            frame_noise_reg <= 1'b0;
            idle_reg        <= 1'b1;
        end
        else if (i_enable)
        begin
            // take the two early samples; the third is the live level
            if (tick && (phase_reg == `URX_PH_S1))
                samp1_reg <= level_reg;
            if (tick && (phase_reg == `URX_PH_S2))
                samp2_reg <= level_reg;
            if (tick)
                phase_reg <= phase_reg + 1'b1;
            if (!rx_en)
            begin
                // disabled unit or receiver abandons any frame at once
                state_reg <= ST_IDLE;
                idle_reg  <= 1'b1;
            end
            else
            begin
                case (state_reg)
                    ST_IDLE:
                    begin
                        // a falling edge marks the start bit
                        if (level_prev_reg & ~level_reg)
                        begin
                            state_reg       <= ST_START;
                            phase_reg       <= 4'h0;
                            bit_cnt_reg     <= 4'h0;
                            shift_reg       <= 9'h000;
                            frame_noise_reg <= 1'b0;
                            idle_reg        <= 1'b0;
                        end
                    end
                    ST_START:
                    begin
                        if (decide)
                        begin
                            // a glitch that is high at the centre is no start
                            if (bit_val)
                            begin
                                state_reg <= ST_IDLE;
                                idle_reg  <= 1'b1;
                            end
                            else
                            begin
                                state_reg <= ST_DATA;
                            end
                            if (bit_nz)
                                frame_noise_reg <= 1'b1;
                        end
                    end
                    ST_DATA:
                    begin
                        if (decide)
                        begin
                            shift_reg[bit_cnt_reg] <= bit_val;
                            bit_cnt_reg <= bit_cnt_reg + 1'b1;
                            if (bit_nz)
                                frame_noise_reg <= 1'b1;
                            if (bit_cnt_reg == nbits - 1'b1)
                                state_reg <= ST_STOP;
                        end
                    end
                    ST_STOP:
                    begin
                        if (decide)
                        begin
                            idle_reg <= 1'b1;
                            // a low stop level may be a break: do not take it as a start
                            if (stop_bad)
                                state_reg <= ST_WAITH;
                            else
                                state_reg <= ST_IDLE;
                        end
                    end
                    ST_WAITH:
                    begin
                        if (level_reg)
                            state_reg <= ST_IDLE;
                    end
                    default:
                    begin
                        state_reg <= ST_IDLE;
                    end
                endcase
            end
        end
    end

    // two-word buffer; an overrun leaves its contents untouched
    always @(posedge i_clock)
    begin
        if (i_reset)
        begin
            wr_ptr_reg  <= 1'b0;
            rd_ptr_reg  <= 1'b0;
            count_reg   <= 2'h0;
            fifo_mem[0] <= 11'h000;
            fifo_mem[1] <= 11'h000;
        end
        else if (i_enable)
        begin
            if (!unit_en)
            begin
                // unit disable discards every buffered word
                wr_ptr_reg <= 1'b0;
                rd_ptr_reg <= 1'b0;
                count_reg  <= 2'h0;
            end
            else
            begin
                if (push)
                begin
                    // a break arrives as zeros with the framing flag set
                    fifo_mem[wr_ptr_reg] <= {stop_bad, par_bad, shift_reg & mask};
                    wr_ptr_reg <= ~wr_ptr_reg;
                end
                if (pop)
                    rd_ptr_reg <= ~rd_ptr_reg;
                if (push & ~pop)
                    count_reg <= count_reg + 1'b1;
                else if (pop & ~push)
                    count_reg <= count_reg - 1'b1;
            end
        end
    end

    // sticky overrun and noise flags; a set in the clearing cycle wins
    always @(posedge i_clock)
    begin
        if (i_reset)
        begin
            overrun_reg <= 1'b0;
            noise_reg   <= 1'b0;
            armed_reg   <= 1'b0;
        end
        else if (i_enable)
        begin
            if (!unit_en)
            begin
                overrun_reg <= 1'b0;
                noise_reg   <= 1'b0;
                armed_reg   <= 1'b0;
            end
            else
            begin
                if (overrun_ev)
                    overrun_reg <= 1'b1;
                else if (pop)
                    overrun_reg <= 1'b0;
                if (push & frame_noise_reg)
                    noise_reg <= 1'b1;
                else if (pop)
                    noise_reg <= 1'b0;
                // the sequence is a status read then a data read
                if (rd_status)
                    armed_reg <= 1'b1;
                else if (rd_data)
                    armed_reg <= 1'b0;
            end
        end
    end

    // interrupt pulse on every transfer and on overrun; noise adds none of its own
    always @(posedge i_clock)
    begin
        if (i_reset)
            o_rx_irq <= 1'b0;
        else if (i_enable)
            o_rx_irq <= receive_interrupt_enable & unit_en & (push | overrun_ev);
    end

    // registered read data; status shows the flags stored with the oldest word
    always @(posedge i_clock)
    begin
        if (i_reset)
            o_rdata <= 16'h0000;
        else if (i_enable)
        begin
            o_rdata <= 16'h0000;
            if (i_rd)
            begin
                case (i_addr)
                    `URX_ADDR_CTRL:
                        o_rdata[`URX_CTRL_W-1:0] <= ctrl_reg;
                    `URX_ADDR_DIVISOR:
                        o_rdata[DIV_W-1:0] <= divisor_reg;
                    `URX_ADDR_STATUS:
                    begin
                        o_rdata[`URX_STAT_AVAIL] <= o_data_available;
                        o_rdata[`URX_STAT_OVR]   <= overrun_reg;
                        o_rdata[`URX_STAT_NOISE] <= noise_reg;
                        // stored flags belong to the head word, so read them first
                        o_rdata[`URX_STAT_FRAMING_ERROR_FLAG]  <= o_data_available & head[10];
                        o_rdata[`URX_STAT_PARITY_ERROR_FLAG]  <= o_data_available & head[9];
                        o_rdata[`URX_STAT_IDLE]  <= idle_reg;
                        o_rdata[`URX_STAT_NINTH] <= o_data_available & head[8];
                    end
                    `URX_ADDR_DATA:
                        o_rdata[7:0] <= o_data_available ? head[7:0] : 8'h00;
                    default:
                        o_rdata <= 16'h0000;
                endcase
            end
        end
    end

endmodule // urx_receiver

// >>> testbench/urx_receiver_chk.sv
// port-level assertion checker for the serial receiver
module urx_receiver_chk
(
    input logic        i_clock,
    input logic        i_reset,
    input logic        i_enable,
    input logic        i_rx_pin,
    input logic [1:0]  i_addr,
    input logic [15:0] i_wdata,
    input logic        i_wr,
    input logic        i_rd,
    input logic [15:0] o_rdata,
    input logic        o_rx_irq,
    input logic        o_data_available,
    input logic        o_receiver_idle
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [5:0] ctl_q;  // shadow of the control register
    logic [7:0] div_q;  // shadow of the divisor
    logic       arm_q;  // status read seen since the last data read
    default clocking cb @(posedge i_clock); endclocking
    default disable iff (i_reset);
    // shadows follow the bus, since the checker cannot look inside
    always_ff @(posedge i_clock)
    begin
        if (i_reset)
        begin
            ctl_q <= 6'h00;
            div_q <= 8'h00;
            arm_q <= 1'b0;
        end
        else if (i_enable && i_wr && i_addr == 2'h0)
            ctl_q <= i_wdata[5:0];
        else if (i_enable && i_wr && i_addr == 2'h1)
            div_q <= i_wdata[7:0];
        else if (i_enable && i_rd && i_addr[1])
            arm_q <= !i_addr[0];  // status arms, data disarms
    end
    AST_DIV_READ: assert property (
        i_rd && i_enable && i_addr == 2'h1 |=> o_rdata == {8'h00, div_q})
        else $error("divisor read back wrong");
    AST_IRQ_PUSH: assert property (
        $rose(o_data_available) && ctl_q[5] && ctl_q[0] |-> o_rx_irq)
        else $error("no interrupt after a word arrived");
    AST_IRQ_ONE: assert property (
        o_rx_irq && i_enable |=> !o_rx_irq)
        else $error("interrupt longer than one cycle");
    AST_IRQ_MASK: assert property (
        !ctl_q[5] && !$past(ctl_q[5]) |-> !o_rx_irq)
        else $error("interrupt while masked");
    AST_IDLE_FRAME: assert property (
        $fell(o_receiver_idle) |-> !o_receiver_idle [*8])
        else $error("idle came back inside a frame");
    AST_PUSH_IDLE: assert property (
        $rose(o_data_available) |-> ##[0:1] o_receiver_idle)
        else $error("word stored but receiver not idle");
    AST_FLUSH: assert property (
        i_wr && i_enable && i_addr == 2'h0 && !i_wdata[0]
        |=> ##1 !o_data_available && o_receiver_idle)
        else $error("unit disable did not flush");
    AST_NO_POP: assert property (
        i_rd && i_enable && i_addr == 2'h3 && !arm_q && o_data_available
        |=> o_data_available)
        else $error("data read popped without status read");
endmodule // urx_receiver_chk

// >>> testbench/urx_tx_model.sv
// behavioural remote transmitter driving the receive line
module urx_tx_model
#(
    parameter int BIT_CLKS = 16  // clocks per bit with divisor zero
)
(
    input  wire logic i_clock,  // bench clock
    output logic      o_line    // serial line, idles high
);
    timeunit 1ns;
    timeprecision 1ps;
    initial o_line = 1'b1;
    // hold a level for n clocks, changing just after each edge
    task automatic hold(input logic lvl, input int n);
        repeat (n) @(posedge i_clock) o_line <= lvl;
    endtask
    // one frame; glitch spikes data bit 0 near its centre, tail stretches the stop level
    task automatic send(input logic [8:0] word, input int nbits, input logic stop,
                        input logic glitch, input int tail);
        int i;
        hold(1'b0, BIT_CLKS);  // start bit
        for (i = 0; i < nbits; i++)
        begin
            // the spike reaches only the last of the three centre samples
            hold(word[i], 10);
            hold(word[i] ^ (glitch && i == 0), 2);  // short spike only on request
            hold(word[i], BIT_CLKS - 12);
        end
        hold(stop, BIT_CLKS + tail);  // low here makes a framing fault or break
        hold(1'b1, 2 * BIT_CLKS);     // line back to its idle level
    endtask
endmodule // urx_tx_model

// >>> testbench/urx_receiver_bench.sv
// self-checking bench for the serial receiver
module urx_receiver_bench;
    timeunit 1ns;
    timeprecision 1ps;
    typedef struct packed {
        logic [5:0]  ctrl;  // control value for the frame
        logic [8:0]  word;  // word sent on the line
        logic        stop;  // stop bit level
        logic [15:0] st;    // expected status
        logic [15:0] dat;   // expected data
    } urx_row_t;
    logic        i_clock = 1'b0;
    logic        i_reset = 1'b1;
    logic        i_enable = 1'b1;  // kept running throughout
    logic [1:0]  i_addr = 2'h0;
    logic [15:0] i_wdata = 16'h0000;
    logic        i_wr = 1'b0;
    logic        i_rd = 1'b0;
    wire         i_rx_pin;
    wire  [15:0] o_rdata;
    wire         o_rx_irq;
    wire         o_data_available;
    wire         o_receiver_idle;
    int          err_total = 0;
    int          checks_done = 0;
    int          irq_cnt = 0;  // interrupt pulses seen
    int          base;
    logic [15:0] q;
    // ordinary frames: formats, parity kinds and a bad stop bit
    urx_row_t rows [8] = '{
        '{6'h23, 9'h0a5, 1'b1, 16'h0021, 16'h00a5}, '{6'h27, 9'h15a, 1'b1, 16'h0061, 16'h005a},
        '{6'h2b, 9'h003, 1'b1, 16'h0021, 16'h0003}, '{6'h2b, 9'h001, 1'b1, 16'h0031, 16'h0001},
        '{6'h3b, 9'h001, 1'b1, 16'h0021, 16'h0001}, '{6'h3f, 9'h003, 1'b1, 16'h0031, 16'h0003},
        '{6'h2f, 9'h101, 1'b1, 16'h0061, 16'h0001}, '{6'h23, 9'h0ff, 1'b0, 16'h0029, 16'h00ff}};
    always #12.5 i_clock = ~i_clock;
    always @(posedge i_clock) if (o_rx_irq === 1'b1) irq_cnt++;
    urx_receiver urx_receiver_i (.i_clock(i_clock), .i_reset(i_reset), .i_enable(i_enable),
        .i_rx_pin(i_rx_pin), .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd),
        .o_rdata(o_rdata), .o_rx_irq(o_rx_irq), .o_data_available(o_data_available),
        .o_receiver_idle(o_receiver_idle));
    urx_tx_model urx_tx_model_i (.i_clock(i_clock), .o_line(i_rx_pin));
    // one write cycle, then a quiet cycle so strobes never collide
    task automatic wr(input logic [1:0] a, input logic [15:0] d);
        i_addr <= a;
        i_wdata <= d;
        i_wr <= 1'b1;
        @(posedge i_clock);
        i_wr <= 1'b0;
        @(posedge i_clock);
    endtask
    // one read cycle; data captured in the single cycle it stands
    task automatic rd(input logic [1:0] a, output logic [15:0] d);
        i_addr <= a;
        i_rd <= 1'b1;
        @(posedge i_clock);
        i_rd <= 1'b0;
        #1 d = o_rdata;
        @(posedge i_clock);
    endtask
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        checks_done++;
        if (seen !== exp)
        begin
            err_total++;
            $display("Error at %0t: got %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic summarize;
        $display("mismatches %0d, comparisons %0d", err_total, checks_done);
        if (err_total == 0 && checks_done > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask
    // watchdog: a hang counts as a mismatch
    initial
    begin
        repeat (100000) @(posedge i_clock);
        err_total++;
        summarize;
    end
    initial
    begin
        repeat (4) @(posedge i_clock);
        i_reset <= 1'b0;
        @(posedge i_clock);
        chk({14'h0000, o_receiver_idle, o_data_available}, 16'h0002);
        rd(2'h0, q);
        chk(q, 16'h0000);
        wr(2'h1, 16'hff00);  // upper divisor bits are ignored
        rd(2'h1, q);
        chk(q, 16'h0000);
        wr(2'h0, 16'h0001);  // unit on, receiver off
        urx_tx_model_i.send(9'h055, 8, 1'b1, 1'b0, 0);
        chk({15'h0000, o_data_available}, 16'h0000);
        foreach (rows[n])
        begin
            base = irq_cnt;
            wr(2'h0, {10'h000, rows[n].ctrl});
            urx_tx_model_i.send(rows[n].word, rows[n].ctrl[2] ? 9 : 8, rows[n].stop, 1'b0, 0);
            rd(2'h2, q);
            chk(q, rows[n].st);
            rd(2'h3, q);
            chk(q, rows[n].dat);
            chk(16'(irq_cnt - base), 16'h0001);
            chk({15'h0000, o_data_available}, 16'h0000);
        end
        // three frames unread: third one is lost
        wr(2'h0, 16'h0023);
        base = irq_cnt;
        urx_tx_model_i.send(9'h011, 8, 1'b1, 1'b0, 0);
        urx_tx_model_i.send(9'h022, 8, 1'b1, 1'b0, 0);
        urx_tx_model_i.send(9'h033, 8, 1'b1, 1'b0, 0);
        rd(2'h3, q);
        chk(q, 16'h0011);
        chk({15'h0000, o_data_available}, 16'h0001);
        rd(2'h2, q);
        chk(q, 16'h0023);
        rd(2'h3, q);
        chk(q, 16'h0011);
        rd(2'h2, q);
        chk(q, 16'h0021);
        rd(2'h3, q);
        chk(q, 16'h0022);
        chk({15'h0000, o_data_available}, 16'h0000);
        chk(16'(irq_cnt - base), 16'h0003);
        // long break in nine-bit mode gives one zero word only
        wr(2'h0, 16'h0027);
        urx_tx_model_i.send(9'h000, 9, 1'b0, 1'b0, 320);
        rd(2'h2, q);
        chk(q, 16'h0029);
        rd(2'h3, q);
        chk(q, 16'h0000);
        chk({15'h0000, o_data_available}, 16'h0000);
        // spike inside a bit flags noise, cleared by the read pair
        wr(2'h0, 16'h0023);
        urx_tx_model_i.send(9'h0a4, 8, 1'b1, 1'b1, 0);
        rd(2'h2, q);
        chk(q, 16'h0025);
        rd(2'h3, q);
        chk(q, 16'h00a4);
        rd(2'h2, q);
        chk(q, 16'h0020);
        // unit disable with a word waiting
        urx_tx_model_i.send(9'h077, 8, 1'b1, 1'b0, 0);
        wr(2'h0, 16'h0002);
        #1;
        chk({14'h0000, o_receiver_idle, o_data_available}, 16'h0002);
        rd(2'h0, q);
        chk(q, 16'h0000);
        summarize;
    end
endmodule // urx_receiver_bench
bind urx_receiver urx_receiver_chk urx_receiver_chk_i (.i_clock(i_clock), .i_reset(i_reset),
    .i_enable(i_enable), .i_rx_pin(i_rx_pin), .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr),
    .i_rd(i_rd), .o_rdata(o_rdata), .o_rx_irq(o_rx_irq), .o_data_available(o_data_available),
    .o_receiver_idle(o_receiver_idle));
